// ### dv/tb.sv
// Self-checking bench for the interrupt priority bank zero register block.
// Assumes ipb_pkg is compiled first; the design carries its own assertions.
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and design under test
  // ****************************************************************
  logic                      clk;
  logic                      reset;
  logic [3:0]                reg_addr;
  logic [15:0]               reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [15:0]               reg_rdata;
  ipb_pkg::ipb_prio_t        prio_out;
  ipb_pkg::ipb_level_t       level_out;
  logic [31:0]               lfsr_state;
  int                        failures;
  int                        n_checks;
  int                        cycles;

  ipb_bank uut (
    .clk       (clk),
    .reset     (reset),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .prio_out  (prio_out),
    .level_out (level_out)
  );

  // ****************************************************************
  // Expectation helpers
  // ****************************************************************
  // Gap bits never store, so the word seen is the write masked
  function automatic logic [15:0] exp_word(input logic [15:0] w);
    return w & 16'h7777;
  endfunction

  // Level equals code; a zero code drops the source from arbitration
  function automatic logic [15:0] exp_lvl(input logic [15:0] w);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[12+i]    = |w[4*i +: 3];
      r[3*i +: 3] = w[4*i +: 3];
    end
    return r;
  endfunction

  // Galois-free shift register, repeatable from the fixed seed
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // ****************************************************************
  // Bus tasks, entered just after a rising edge
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask

  // Outputs settle two cycles after the write strobe edge
  task automatic chk_out(input logic [15:0] w);
    logic [15:0] lv;
    lv = exp_lvl(w);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("prio_out", lv[11:0], prio_out)
    `CHK("level_out", lv, level_out)
    @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [15:0] got;
    logic [15:0] w;
    logic [15:0] cur;
    logic [2:0]  c;
    reset = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
    failures = 0; n_checks = 0; cycles = 0; lfsr_state = 32'hc3d3;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(4'h0, got);
    `CHK("reset word", 16'h4444, got)
    chk_out(16'h4444);
    $display("reset values done");
    // Every code in every field, shifted per field, gap bits set
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      w = {1'b1, c, 1'b1, c + 3'h1, 1'b1, c + 3'h2, 1'b1, c + 3'h3};
      wr(4'h0, w);
      rd(4'h0, got);
      `CHK("code word", exp_word(w), got)
      chk_out(exp_word(w));
    end
    $display("code sweep done");
    // Random words, each write followed at once by a read
    repeat (40) begin
      lfsr_state = lfsr_next(lfsr_state);
      w = lfsr_state[15:0];
      wr(4'h0, w);
      rd(4'h0, got);
      `CHK("random word", exp_word(w), got)
      chk_out(exp_word(w));
    end
    cur = exp_word(w);
    $display("random traffic done");
    // Unmapped place: write lost, read zero
    lfsr_state = lfsr_next(lfsr_state);
    wr(4'h9, lfsr_state[15:0]);
    rd(4'h9, got);
    `CHK("unmapped read", 16'h0000, got)
    rd(4'h0, got);
    `CHK("after unmapped", cur, got)
    chk_out(cur);
    $display("unmapped access done");
    // Second reset in mid-run restores every field
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(4'h0, got);
    `CHK("re-reset word", 16'h4444, got)
    chk_out(16'h4444);
    $display("mid-run reset done");
    results();
  end
endmodule

// ### include/ipb_pkg.sv
// Package for the interrupt priority bank zero register block.
// Assumes a single 100 MHz clock and a plain strobe register port.
package ipb_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  BANK_ZERO_ADDR = 4'h0;  // Word address of the register
  localparam int          DATA_W         = 16;
  localparam int          PRIO_W         = 3;
  localparam int          NUM_SRC        = 4;

  // Field positions (low bit of each field)
  localparam int TIMER_ONE_LSB   = 12;
  localparam int COMPARE_ONE_LSB = 8;
  localparam int CAPTURE_ONE_LSB = 4;
  localparam int EXT_ZERO_LSB    = 0;

  // Reset value of each field and the writable bit mask
  localparam logic [2:0]  PRIO_RESET     = 3'h4;
  localparam logic [15:0] BANK_RESET     = 16'h4444;
  localparam logic [15:0] BANK_WR_MASK   = 16'h7777;

  // Codes with defined meaning
  localparam logic [2:0]  PRIO_OFF       = 3'h0;
  localparam logic [2:0]  PRIO_TOP       = 3'h7;

  // Priority fields carried as one group
  typedef struct packed {
    logic [2:0] timer_one_prio_field;
    logic [2:0] compare_one_prio_field;
    logic [2:0] capture_one_prio_field;
    logic [2:0] ext_irq_zero_prio_field;
  } ipb_prio_t;

  // Source priority levels after decode, plus enable flags
  typedef struct packed {
    logic [3:0]  enabled;
    logic [11:0] levels;
  } ipb_level_t;

endpackage

// ### src/ipb_bank.sv
// Interrupt priority bank zero: four 3-bit priority fields.
// Assumes a one-cycle strobe register port, read data one cycle later.
//
// Summary of operation
// - Bits 14:12 hold the timer one priority, readable and writable.
// - Bits 10:8 hold the output compare one priority, readable and writable.
// - Bits 6:4 hold the input capture one priority, readable and writable.
// - Code 111 gives its source level 7, the highest level.
// - Code 001 gives level 1, the lowest active one, and codes between map linearly.
module ipb_bank (
  input  wire logic                           clk,        // System clock
  input  wire logic                           reset,      // Synchronous reset
  input  wire logic [ipb_pkg::ADDR_W-1:0]     reg_addr,   // Register word address
  input  wire logic [ipb_pkg::DATA_W-1:0]     reg_wdata,  // Write data
  input  wire logic                           reg_wr,     // Write strobe
  input  wire logic                           reg_rd,     // Read strobe
  output logic      [ipb_pkg::DATA_W-1:0]     reg_rdata,  // Read data, cycle after strobe
  output ipb_pkg::ipb_prio_t                  prio_out,   // Stored priority fields
  output ipb_pkg::ipb_level_t                 level_out   // Decoded levels and enables
);

  // ****************************************************************
  // Write decode
  // ****************************************************************

  // Extract one field from a bus word
  function automatic logic [2:0] field_of(input logic [15:0] w, input int lsb);
    logic [15:0] s;
    s = w >> lsb;
    return s[2:0];
  endfunction

  logic        hit_wr;
  logic        hit_rd;
  logic [2:0]  f_timer;
  logic [2:0]  f_cmp;
  logic [2:0]  f_cap;
  logic [2:0]  f_ext;

  // Address match; other addresses write nothing and read zero
  assign hit_wr = reg_wr && (reg_addr == ipb_pkg::BANK_ZERO_ADDR);
  assign hit_rd = reg_rd && (reg_addr == ipb_pkg::BANK_ZERO_ADDR);

  // ****************************************************************
  // Field storage
  // ****************************************************************

  // Timer one field
  ipb_field u_timer (
    .clk    (clk),
    .reset  (reset),
    .wr_en  (hit_wr),
    .wr_val (field_of(reg_wdata, ipb_pkg::TIMER_ONE_LSB)),
    .value  (f_timer)
  );

  // Output compare one field
  ipb_field u_cmp (
    .clk    (clk),
    .reset  (reset),
    .wr_en  (hit_wr),
    .wr_val (field_of(reg_wdata, ipb_pkg::COMPARE_ONE_LSB)),
    .value  (f_cmp)
  );

  // Input capture one field
  ipb_field u_cap (
    .clk    (clk),
    .reset  (reset),
    .wr_en  (hit_wr),
    .wr_val (field_of(reg_wdata, ipb_pkg::CAPTURE_ONE_LSB)),
    .value  (f_cap)
  );

  // External line zero field, reset 100 like the rest
  ipb_field u_ext (
    .clk    (clk),
    .reset  (reset),
    .wr_en  (hit_wr),
    .wr_val (field_of(reg_wdata, ipb_pkg::EXT_ZERO_LSB)),
    .value  (f_ext)
  );

  // ****************************************************************
  // Level decode
  // ****************************************************************

  logic [2:0] lv_timer;
  logic [2:0] lv_cmp;
  logic [2:0] lv_cap;
  logic [2:0] lv_ext;
  logic [3:0] act;

  // Linear decode shared by all four sources
  ipb_level u_lv_timer (.code(f_timer), .level(lv_timer), .active(act[3]));
  ipb_level u_lv_cmp   (.code(f_cmp),   .level(lv_cmp),   .active(act[2]));
  ipb_level u_lv_cap   (.code(f_cap),   .level(lv_cap),   .active(act[1]));
  ipb_level u_lv_ext   (.code(f_ext),   .level(lv_ext),   .active(act[0]));

  // ****************************************************************
  // Output registers
  // ****************************************************************

  logic [15:0]          rdata_reg;
  logic [15:0]          rdata_next;
  ipb_pkg::ipb_prio_t   prio_reg;
  ipb_pkg::ipb_prio_t   prio_next;
  ipb_pkg::ipb_level_t  level_reg;
  ipb_pkg::ipb_level_t  level_next;

  // Read word packs fields; gap bits 15, 11, 7, 3 stay zero
  always_comb begin
    rdata_next = 16'h0000;
    if (hit_rd) begin
      rdata_next = {1'b0, f_timer, 1'b0, f_cmp, 1'b0, f_cap, 1'b0, f_ext};
    end
    prio_next.timer_one_prio_field    = f_timer;
    prio_next.compare_one_prio_field  = f_cmp;
    prio_next.capture_one_prio_field  = f_cap;
    prio_next.ext_irq_zero_prio_field = f_ext;
    level_next.enabled = act;
    level_next.levels  = {lv_timer, lv_cmp, lv_cap, lv_ext};
  end

  // Outputs come from flops; arbitration sees values one cycle after the field
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
      prio_reg  <= {4{ipb_pkg::PRIO_RESET}};  // Struct is 12 bits, not the register layout
      level_reg <= {4'hf, ipb_pkg::BANK_RESET[14:12], ipb_pkg::BANK_RESET[10:8],
                    ipb_pkg::BANK_RESET[6:4], ipb_pkg::BANK_RESET[2:0]};
    end else begin
      rdata_reg <= rdata_next;
      prio_reg  <= prio_next;
      level_reg <= level_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign prio_out  = prio_reg;
  assign level_out = level_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************

  sequence s_write_bank;
    reg_wr && reg_addr == ipb_pkg::BANK_ZERO_ADDR && !reg_rd;
  endsequence

  sequence s_read_bank;
    reg_rd && reg_addr == ipb_pkg::BANK_ZERO_ADDR;
  endsequence

  chk_timer_field_write: assert property (@(posedge clk) disable iff (reset)
    s_write_bank |-> ##2 prio_out.timer_one_prio_field == $past(reg_wdata[14:12], 2))
    else $error("timer one field not stored");

  chk_compare_write: assert property (@(posedge clk) disable iff (reset)
    s_write_bank |-> ##2 prio_out.compare_one_prio_field == $past(reg_wdata[10:8], 2))
    else $error("compare one field not stored");

  chk_capture_write: assert property (@(posedge clk) disable iff (reset)
    s_write_bank |-> ##2 prio_out.capture_one_prio_field == $past(reg_wdata[6:4], 2))
    else $error("capture one field not stored");

  chk_ext_write: assert property (@(posedge clk) disable iff (reset)
    s_write_bank |-> ##2 prio_out.ext_irq_zero_prio_field == $past(reg_wdata[2:0], 2))
    else $error("external zero field not stored");

  chk_top_level_code: assert property (@(posedge clk) disable iff (reset)
    prio_out.timer_one_prio_field == ipb_pkg::PRIO_TOP |->
      level_out.levels[11:9] == 3'h7 && level_out.enabled[3])
    else $error("code 111 not level 7");

  chk_linear_levels: assert property (@(posedge clk) disable iff (reset)
    level_out.levels == {prio_out.timer_one_prio_field, prio_out.compare_one_prio_field,
                         prio_out.capture_one_prio_field, prio_out.ext_irq_zero_prio_field})
    else $error("level map not linear");

  chk_off_disables: assert property (@(posedge clk) disable iff (reset)
    level_out.enabled[0] == (prio_out.ext_irq_zero_prio_field != ipb_pkg::PRIO_OFF))
    else $error("code 000 enable mismatch");

  chk_read_gap_zero: assert property (@(posedge clk) disable iff (reset)
    s_read_bank |=> (reg_rdata & ~ipb_pkg::BANK_WR_MASK) == 16'h0000 &&
      reg_rdata[14:12] == prio_out.timer_one_prio_field)
    else $error("read word wrong");

  chk_reset_value: assert property (@(posedge clk)
    $past(reset) |-> prio_out == {4{ipb_pkg::PRIO_RESET}})
    else $error("fields not reset to 100");

  // Levels must leave reset consistent with the fields they decode
  chk_reset_levels: assert property (@(posedge clk)
    $past(reset) |-> level_out == {4'hf, {4{ipb_pkg::PRIO_RESET}}})
    else $error("levels not reset to 100");

  // ****************************************************************
  // Read port checks
  // ****************************************************************

  // Any cycle without a bank read
  sequence s_no_read;
    !(reg_rd && reg_addr == ipb_pkg::BANK_ZERO_ADDR);
  endsequence

  // Idle and unmapped reads show zero, so a stale word never leaks
  chk_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    s_no_read |=> reg_rdata == 16'h0000)
    else $error("read data not zero when idle");

  // Full read word against the stored fields, gaps as zero
  chk_read_word_full: assert property (@(posedge clk) disable iff (reset)
    s_read_bank |=> reg_rdata == {1'b0, prio_out.timer_one_prio_field,
                                  1'b0, prio_out.compare_one_prio_field,
                                  1'b0, prio_out.capture_one_prio_field,
                                  1'b0, prio_out.ext_irq_zero_prio_field})
    else $error("read word does not match fields");

  // ****************************************************************
  // Storage checks
  // ****************************************************************

  // Cycles with no write to the bank, unmapped writes included
  sequence s_no_write;
    !(reg_wr && reg_addr == ipb_pkg::BANK_ZERO_ADDR);
  endsequence

  // Field outputs trail storage by one cycle, hence the extra cycle before the compare
  chk_fields_hold: assert property (@(posedge clk) disable iff (reset)
    s_no_write |=> ##1 $stable(prio_out))
    else $error("field changed without a write");

  // Levels follow a write through the same two-cycle path as the fields
  chk_level_after_write: assert property (@(posedge clk) disable iff (reset)
    s_write_bank |-> ##2 level_out.levels == {$past(reg_wdata[14:12], 2),
      $past(reg_wdata[10:8], 2), $past(reg_wdata[6:4], 2), $past(reg_wdata[2:0], 2)})
    else $error("levels do not follow write");

  // A late enable would let a disabled source win arbitration for a cycle,
  // so the enables must move in the same cycle as the levels
  chk_enable_after_write: assert property (@(posedge clk) disable iff (reset)
    s_write_bank |-> ##2 level_out.enabled == {|$past(reg_wdata[14:12], 2),
      |$past(reg_wdata[10:8], 2), |$past(reg_wdata[6:4], 2), |$past(reg_wdata[2:0], 2)})
    else $error("enables do not follow write");

  // ****************************************************************
  // Decode checks per source for top, low and off codes
  // ****************************************************************

  // Each source is checked on its own so a failure names the field
  // Top code gives the highest level on every source
  chk_compare_top_code: assert property (@(posedge clk) disable iff (reset)
    prio_out.compare_one_prio_field == ipb_pkg::PRIO_TOP |->
      level_out.levels[8:6] == 3'h7 && level_out.enabled[2])
    else $error("compare code 111 not level 7");

  chk_capture_top_code: assert property (@(posedge clk) disable iff (reset)
    prio_out.capture_one_prio_field == ipb_pkg::PRIO_TOP |->
      level_out.levels[5:3] == 3'h7 && level_out.enabled[1])
    else $error("capture code 111 not level 7");

  chk_ext_top_code: assert property (@(posedge clk) disable iff (reset)
    prio_out.ext_irq_zero_prio_field == ipb_pkg::PRIO_TOP |->
      level_out.levels[2:0] == 3'h7 && level_out.enabled[0])
    else $error("external code 111 not level 7");

  // Code 001 is the lowest active level on every source
  chk_timer_low_code: assert property (@(posedge clk) disable iff (reset)
    prio_out.timer_one_prio_field == 3'h1 |->
      level_out.levels[11:9] == 3'h1 && level_out.enabled[3])
    else $error("timer code 001 not level 1");

  chk_compare_low_code: assert property (@(posedge clk) disable iff (reset)
    prio_out.compare_one_prio_field == 3'h1 |->
      level_out.levels[8:6] == 3'h1 && level_out.enabled[2])
    else $error("compare code 001 not level 1");

  chk_capture_low_code: assert property (@(posedge clk) disable iff (reset)
    prio_out.capture_one_prio_field == 3'h1 |->
      level_out.levels[5:3] == 3'h1 && level_out.enabled[1])
    else $error("capture code 001 not level 1");

  chk_ext_low_code: assert property (@(posedge clk) disable iff (reset)
    prio_out.ext_irq_zero_prio_field == 3'h1 |->
      level_out.levels[2:0] == 3'h1 && level_out.enabled[0])
    else $error("external code 001 not level 1");

  // Code 000 drops its own source from arbitration; checked here for the other three sources
  chk_timer_off: assert property (@(posedge clk) disable iff (reset)
    level_out.enabled[3] == (prio_out.timer_one_prio_field != ipb_pkg::PRIO_OFF))
    else $error("timer code 000 enable mismatch");

  chk_compare_off: assert property (@(posedge clk) disable iff (reset)
    level_out.enabled[2] == (prio_out.compare_one_prio_field != ipb_pkg::PRIO_OFF))
    else $error("compare code 000 enable mismatch");

  chk_capture_off: assert property (@(posedge clk) disable iff (reset)
    level_out.enabled[1] == (prio_out.capture_one_prio_field != ipb_pkg::PRIO_OFF))
    else $error("capture code 000 enable mismatch");

endmodule

// ### src/ipb_field.sv
// One 3-bit priority field with reset value and write enable.
// Assumes the parent decodes the address and selects the bits.
module ipb_field (
  input  wire logic       clk,      // System clock
  input  wire logic       reset,    // Synchronous reset, active high
  input  wire logic       wr_en,    // Field write this cycle
  input  wire logic [2:0] wr_val,   // New field value
  output logic      [2:0] value     // Stored field value
);

  logic [2:0] value_reg;
  logic [2:0] value_next;

  // Next value: hold unless written
  always_comb begin
    value_next = value_reg;
    if (wr_en) begin
      value_next = wr_val;
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (reset) begin
      value_reg <= ipb_pkg::PRIO_RESET;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

// ### src/ipb_level.sv
// Decodes one priority code into a level and an enable flag.
// Pure combinational; the parent registers the result.
module ipb_level (
  input  wire logic [2:0] code,     // Field code
  output logic      [2:0] level,    // Arbitration level, 0 when off
  output logic            active    // Source takes part in arbitration
);

  // Linear code-to-level map; code zero means the source is off
  always_comb begin
    active = (code != ipb_pkg::PRIO_OFF);
    level  = code;
  end

endmodule
